// >>> hw/pmc_power_ctrl.sv
// Power mode controller: idle, power-down, wake and pin states
// Operation
// RULE_01 - Idle stops CPU clock in known state, peripherals stay clocked, execution halts.
// RULE_02 - Idle keeps program counter, status word, registers and RAM unchanged.
// RULE_03 - Idle entered when instruction sets idle bit; it is the last completed.
// RULE_04 - Both bits set enters power-down only; no idle after exit.
// RULE_05 - Enabled interrupt in idle clears idle bit and restores CPU clock.
// RULE_06 - Reset pin clears idle bit asynchronously and restores CPU clock.
// RULE_07 - Before reset takes control, RAM access blocked, port access allowed.
// RULE_08 - Power-down stops oscillator and freezes all clocks, preserving state.
// RULE_09 - Power-down entered when instruction sets power-down bit, last executed.
// RULE_10 - Only external lines wake power-down; clear bit, restart oscillator, clocks.
// RULE_11 - After line wake, execution held until interrupt line released.
// RULE_12 - Waking source holds level line long enough for oscillator to settle.
// RULE_13 - Interrupt wake from power-down leaves registers and RAM untouched.
// RULE_14 - Reset pin in power-down clears bit asynchronously, restarts oscillator.
// RULE_15 - Idle strobes high, power-down strobes low; ports hold, first floats externally.
// RULE_16 - During reset first port floats, others high, both strobes high.
// RULE_17 - General flags are plain software storage with no hardware effect.
// RULE_18 - Wake from external lines and reset works without a running clock; a line wake is latched, but leaving power-down needs a clock edge.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pmc_power_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic instr_done_i,
    input wire logic irq_enabled_i,
    input wire logic ext_irq_line_zero_n_i,
    input wire logic ext_irq_line_one_n_i,
    input wire logic ext_code_i,
    input wire logic [7:0] port0_data_i,
    input wire logic [7:0] port1_data_i,
    input wire logic [7:0] port2_data_i,
    input wire logic [7:0] port3_data_i,
    input wire logic [7:0] port4_data_i,
    input wire logic cpu_ale_i,
    input wire logic cpu_program_store_strobe_n_i,
    output logic osc_enable_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic cpu_hold_o,
    output logic ram_block_o,
    output logic [7:0] port0_o,
    output logic port0_oe_o,
    output logic [7:0] port1_o,
    output logic [7:0] port2_o,
    output logic [7:0] port3_o,
    output logic [7:0] port4_o,
    output logic ale_o,
    output logic program_store_strobe_n_o,
    output logic [1:0] wake_flags_o
);
    pmc_pkg::pmc_state_e state_reg, state_next;
    logic idle_request_bit_reg;
    logic powerdown_request_bit_reg;
    logic general_flag_zero_reg;
    logic general_flag_one_reg;
    logic pending_idle_reg, pending_pd_reg;
    logic [7:0] osc_cnt_reg, osc_cnt_next;
    logic [7:0] blk_cnt_reg;
    logic [1:0] irq_sync_n;
    logic wake_zero_reg;
    logic wake_one_reg;
    logic [7:0] rdata_reg;

    wire pwr_sel = addr_i == pmc_pkg::PWR_CTRL_ADDR;
    wire pwr_wr = wr_i && pwr_sel;
    wire pwr_rd = rd_i && pwr_sel;
    wire any_line_low = !ext_irq_line_zero_n_i || !ext_irq_line_one_n_i;
    wire lines_low_sync = !(irq_sync_n[0] && irq_sync_n[1]);
    wire in_run = state_reg == pmc_pkg::PMC_RUN;
    wire in_idle = state_reg == pmc_pkg::PMC_IDLE;
    wire in_pdown = state_reg == pmc_pkg::PMC_PDOWN;
    wire in_wake = state_reg == pmc_pkg::PMC_WAKE;
    wire osc_ready = osc_cnt_reg == 8'h00;
    wire pd_req_w = pwr_wr && wdata_i[pmc_pkg::PDOWN_BIT];
    wire idle_req_w = pwr_wr && wdata_i[pmc_pkg::IDLE_BIT];
    wire stopped = in_pdown || in_wake;
    wire blk_active = blk_cnt_reg != 8'h00;
    wire logic [1:0] wake_flags_w = {wake_one_reg, wake_zero_reg};
    wire logic [7:0] pwr_ctrl_word = {4'h0, general_flag_one_reg, general_flag_zero_reg,
        powerdown_request_bit_reg, idle_request_bit_reg};

    // Strobe level for reset, idle, power-down and run
    function automatic logic strobe_level(input logic rst, input logic idle,
        input logic stop, input logic cpu);
        if (rst || idle) begin
            return 1'b1;
        end
        if (stop) begin
            return 1'b0;
        end
        return cpu;
    endfunction

    // Port level: forced high in reset, CPU data otherwise
    function automatic logic [7:0] port_level(input logic rst, input logic [7:0] data);
        if (rst) begin
            return pmc_pkg::PORT_HIGH;
        end
        return data;
    endfunction


    // Line wake is latched without a clock, since the oscillator is stopped
    // Flags are cleared once the power-down bit drops, so a later entry starts clean
    wire wake_clr = rst_i || !powerdown_request_bit_reg;

    always_ff @(posedge wake_clr or negedge ext_irq_line_zero_n_i) begin // RULE_18
        if (wake_clr) begin
            wake_zero_reg <= 1'b0;
        end else begin
            wake_zero_reg <= in_pdown; // RULE_10
        end
    end

    always_ff @(posedge wake_clr or negedge ext_irq_line_one_n_i) begin // RULE_18
        if (wake_clr) begin
            wake_one_reg <= 1'b0;
        end else begin
            wake_one_reg <= in_pdown; // RULE_10
        end
    end

    pmc_sync #(
        .WIDTH(2)
    ) u_irq_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({ext_irq_line_one_n_i, ext_irq_line_zero_n_i}),
        .sync_o(irq_sync_n)
    );

    // General flags are cleared by reset directly and asynchronously
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            general_flag_zero_reg <= 1'b0;
            general_flag_one_reg <= 1'b0;
        end else if (pwr_wr) begin
            general_flag_zero_reg <= wdata_i[pmc_pkg::GF0_BIT]; // RULE_17
            general_flag_one_reg <= wdata_i[pmc_pkg::GF1_BIT]; // RULE_17
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_request_bit_reg <= 1'b0; // RULE_06
            powerdown_request_bit_reg <= 1'b0; // RULE_14
        end else begin
            if (in_idle && irq_enabled_i) begin
                idle_request_bit_reg <= 1'b0; // RULE_05
            end else if (pwr_wr) begin
                idle_request_bit_reg <= wdata_i[pmc_pkg::IDLE_BIT];
            end
            if (in_wake) begin
                powerdown_request_bit_reg <= 1'b0; // RULE_10
                idle_request_bit_reg <= 1'b0; // RULE_04
            end else if (pwr_wr) begin
                powerdown_request_bit_reg <= wdata_i[pmc_pkg::PDOWN_BIT];
            end
        end
    end

    // Entry waits for the requesting instruction to complete
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_idle_reg <= 1'b0;
            pending_pd_reg <= 1'b0;
        end else begin
            pending_pd_reg <= (pending_pd_reg || pd_req_w) && !instr_done_i; // RULE_09
            pending_idle_reg <= (pending_idle_reg || idle_req_w) && !instr_done_i; // RULE_03
        end
    end

    always_comb begin
        state_next = state_reg;
        osc_cnt_next = osc_cnt_reg;
        unique case (state_reg)
            pmc_pkg::PMC_RUN: begin
                if ((pending_pd_reg || pd_req_w) && instr_done_i) begin
                    state_next = pmc_pkg::PMC_PDOWN; // RULE_04
                end else if ((pending_idle_reg || idle_req_w) && instr_done_i) begin
                    state_next = pmc_pkg::PMC_IDLE; // RULE_03
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (irq_enabled_i) begin
                    state_next = pmc_pkg::PMC_RUN; // RULE_05
                end
            end
            pmc_pkg::PMC_PDOWN: begin
                if (wake_flags_w != 2'b00 || any_line_low) begin
                    state_next = pmc_pkg::PMC_WAKE; // RULE_10
                    osc_cnt_next = pmc_pkg::OSC_START_CNT;
                end
            end
            pmc_pkg::PMC_WAKE: begin
                if (osc_cnt_reg != 8'h00) begin
                    osc_cnt_next = osc_cnt_reg - 8'h01;
                end
                if (osc_ready && !lines_low_sync) begin
                    state_next = pmc_pkg::PMC_RUN; // RULE_11
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= pmc_pkg::PMC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Oscillator start-up counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_cnt_reg <= 8'h00;
        end else begin
            osc_cnt_reg <= osc_cnt_next;
        end
    end

    // RAM is locked for a short window after release of reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blk_cnt_reg <= pmc_pkg::RST_BLOCK_CNT; // RULE_07
        end else if (blk_active) begin
            blk_cnt_reg <= blk_cnt_reg - 8'h01;
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else if (pwr_rd) begin
            rdata_reg <= pwr_ctrl_word;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_o = rdata_reg;
    assign wake_flags_o = wake_flags_w;
    // Oscillator runs except in power-down; reset restarts it
    assign osc_enable_o = rst_i || !in_pdown; // RULE_08 RULE_14
    assign periph_clk_en_o = osc_enable_o && !in_wake; // RULE_01 RULE_10
    assign cpu_clk_en_o = rst_i || in_run; // RULE_01 RULE_06
    assign cpu_hold_o = !rst_i && !in_run; // RULE_02 RULE_13 RULE_11
    assign ram_block_o = rst_i || blk_active; // RULE_07

    // Pin levels for reset, idle and power-down
    assign port0_o = port0_data_i; // RULE_15
    assign port0_oe_o = !rst_i && !ext_code_i; // RULE_15 RULE_16
    assign port1_o = port_level(rst_i, port1_data_i); // RULE_16
    assign port2_o = port_level(rst_i, port2_data_i); // RULE_16
    assign port3_o = port_level(rst_i, port3_data_i); // RULE_16
    assign port4_o = port_level(rst_i, port4_data_i); // RULE_16

    // Address-latch and program-store strobes
    assign ale_o = strobe_level(rst_i, in_idle, stopped, cpu_ale_i); // RULE_15 RULE_16
    assign program_store_strobe_n_o = strobe_level(rst_i, in_idle, stopped,
        cpu_program_store_strobe_n_i); // RULE_15 RULE_16
endmodule // pmc_power_ctrl

// >>> hw/pmc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pmc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '1;
            sync_o <= '1;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule // pmc_sync

// >>> inc/pmc_pkg.sv
// Constants and types for the power mode controller
package pmc_pkg;
    localparam logic [3:0] PWR_CTRL_ADDR = 4'h7;
    localparam int IDLE_BIT = 0;
    localparam int PDOWN_BIT = 1;
    localparam int GF0_BIT = 2;
    localparam int GF1_BIT = 3;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
    localparam logic [7:0] PORT_HIGH = 8'hFF;
    localparam int OSC_START_NS = 100;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_BLOCK_NS = 40;
    localparam int RST_BLOCK_CYC = (RST_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] OSC_START_CNT = 8'(OSC_START_CYC);
    localparam logic [7:0] RST_BLOCK_CNT = 8'(RST_BLOCK_CYC);
    typedef enum logic [3:0] {
        PMC_RUN = 4'b0001,
        PMC_IDLE = 4'b0010,
        PMC_PDOWN = 4'b0100,
        PMC_WAKE = 4'b1000
    } pmc_state_e;
endpackage

// >>> testbench/pmc_irq_src.sv
// Model of the external interrupt sources on the two wake lines
`timescale 1ns/1ps
module pmc_irq_src #(
    parameter int HOLD_CYC = 30
) (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic sel_i,
    output logic zero_n_o,
    output logic one_n_o
);
    int cnt = 0;
    logic sel_reg = 1'b0;
    always @(posedge clk_i) begin
        if (start_i) begin
            cnt <= HOLD_CYC;
            sel_reg <= sel_i;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Level held low past oscillator start, pulled high otherwise
    assign zero_n_o = !(cnt > 0 && !sel_reg);
    assign one_n_o = !(cnt > 0 && sel_reg);
endmodule // pmc_irq_src

// >>> testbench/pmc_power_ctrl_sva.sv
// Assertions on the power mode controller ports
`timescale 1ns/1ps
module pmc_power_ctrl_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic instr_done_i,
    input wire logic irq_enabled_i,
    input wire logic ext_irq_line_zero_n_i,
    input wire logic ext_irq_line_one_n_i,
    input wire logic ext_code_i,
    input wire logic osc_enable_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic cpu_hold_o,
    input wire logic ram_block_o,
    input wire logic port0_oe_o,
    input wire logic [7:0] port1_o,
    input wire logic ale_o,
    input wire logic program_store_strobe_n_o
);
    wire logic wr_pc = wr_i && addr_i == pmc_pkg::PWR_CTRL_ADDR && instr_done_i;
    wire logic lines_hi = ext_irq_line_zero_n_i && ext_irq_line_one_n_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_reset_pins: assert property (
        disable iff (1'b0) rst_i |-> port1_o == 8'hFF && ale_o && program_store_strobe_n_o
        && !port0_oe_o) else $error("pins wrong in reset");
    a_idle_entry: assert property (
        wr_pc && wdata_i[1:0] == 2'b01 && !cpu_hold_o |=> cpu_hold_o && periph_clk_en_o)
        else $error("idle not entered");
    a_pdown_entry: assert property (
        wr_pc && wdata_i[1] && !cpu_hold_o && lines_hi |=> !osc_enable_o)
        else $error("power-down not entered");
    a_idle_pins: assert property (
        cpu_hold_o && periph_clk_en_o |-> ale_o && program_store_strobe_n_o && !cpu_clk_en_o)
        else $error("idle pins wrong");
    a_pdown_pins: assert property (
        !osc_enable_o |-> !ale_o && !program_store_strobe_n_o && !periph_clk_en_o)
        else $error("power-down pins wrong");
    a_idle_exit: assert property (
        cpu_hold_o && periph_clk_en_o && irq_enabled_i |-> ##[1:2] cpu_clk_en_o && !cpu_hold_o)
        else $error("idle not left on interrupt");
    a_line_wake: assert property (
        !osc_enable_o && !lines_hi |-> ##[0:1] osc_enable_o) else $error("no wake");
    a_osc_settle: assert property (
        $rose(osc_enable_o) |-> cpu_hold_o [*8]) else $error("released before settle");
    a_hold_line: assert property (
        cpu_hold_o && !periph_clk_en_o && !lines_hi |=> cpu_hold_o)
        else $error("released while line low");
    a_ext_float: assert property (
        ext_code_i |-> !port0_oe_o) else $error("first port driven");
    a_ram_block: assert property (
        $fell(rst_i) |-> ram_block_o [*6] ##[1:4] !ram_block_o) else $error("ram block span");
endmodule // pmc_power_ctrl_sva
bind pmc_power_ctrl pmc_power_ctrl_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .instr_done_i(instr_done_i), .irq_enabled_i(irq_enabled_i),
    .ext_irq_line_zero_n_i(ext_irq_line_zero_n_i), .ext_irq_line_one_n_i(ext_irq_line_one_n_i),
    .ext_code_i(ext_code_i), .osc_enable_o(osc_enable_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .cpu_hold_o(cpu_hold_o), .ram_block_o(ram_block_o),
    .port0_oe_o(port0_oe_o), .port1_o(port1_o), .ale_o(ale_o),
    .program_store_strobe_n_o(program_store_strobe_n_o));

// >>> testbench/pmc_power_ctrl_tb_top.sv
// Testbench for the power mode controller
`timescale 1ns/1ps
module pmc_power_ctrl_tb_top;
    localparam logic [3:0] PCA = pmc_pkg::PWR_CTRL_ADDR;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic instr_done_i = 1'b0;
    logic irq_enabled_i = 1'b0;
    logic ext_code_i = 1'b0;
    logic [7:0] pdat = 8'h5A;
    logic start = 1'b0;
    logic sel = 1'b0;
    logic rd_dly = 1'b0;
    logic [7:0] g, rdata_o, port1_o;
    logic [15:0] ent;
    logic [15:0] exp_q[$];
    logic l0_n, l1_n, osc_enable_o, cpu_clk_en_o, periph_clk_en_o, cpu_hold_o, ram_block_o;
    logic port0_oe_o, ale_o, program_store_strobe_n_o;
    logic [7:0] port0_o, port2_o;
    logic [1:0] wake_flags_o;
    int check_count = 0;
    int miscompares = 0;
    pmc_irq_src src_u (.clk_i(clk_i), .start_i(start), .sel_i(sel), .zero_n_o(l0_n),
        .one_n_o(l1_n));
    pmc_power_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .instr_done_i(instr_done_i),
        .irq_enabled_i(irq_enabled_i), .ext_irq_line_zero_n_i(l0_n),
        .ext_irq_line_one_n_i(l1_n), .ext_code_i(ext_code_i), .port0_data_i(pdat),
        .port1_data_i(pdat), .port2_data_i(pdat), .port3_data_i(pdat), .port4_data_i(pdat),
        .cpu_ale_i(pdat[0]), .cpu_program_store_strobe_n_i(pdat[1]),
        .osc_enable_o(osc_enable_o), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .cpu_hold_o(cpu_hold_o), .ram_block_o(ram_block_o),
        .port0_o(port0_o), .port0_oe_o(port0_oe_o), .port1_o(port1_o), .port2_o(port2_o),
        .port3_o(), .port4_o(), .ale_o(ale_o),
        .program_store_strobe_n_o(program_store_strobe_n_o), .wake_flags_o(wake_flags_o));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic done);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        instr_done_i <= done;
        @(posedge clk_i);
        wr_i <= 1'b0;
        instr_done_i <= 1'b0;
    endtask
    // Expected read value and mask are queued for the monitor
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic wait_hold(input logic v);
        int n;
        n = 0;
        while (cpu_hold_o !== v && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk(cpu_hold_o, v);
        @(posedge clk_i);
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) rd_dly <= rd_i;
    always @(negedge clk_i) begin
        if (rd_dly) begin
            ent = exp_q.pop_front();
            chk(16'(rdata_o & ent[15:8]), 16'(ent[7:0]));
        end
    end
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #(5 * 4000);
        miscompares++;
        stop_test;
    end
    initial begin
        void'($urandom(42105));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        pdat <= 8'($urandom);
        ext_code_i <= 1'b1;
        g = 8'($urandom) & 8'hFC;
        @(posedge clk_i);
        rd(PCA, 8'hFF, pmc_pkg::PWR_CTRL_RESET);
        wr(4'h3, 8'hFF, 1'b1);
        rd(4'h3, 8'hFF, 8'h00);
        wr(PCA, g, 1'b0);
        rd(PCA, 8'hFF, g & 8'h0C);
        @(negedge clk_i);
        chk({port0_oe_o, port1_o, ale_o}, {1'b0, pdat, pdat[0]});
        chk({port0_o, port2_o}, {pdat, pdat});
        @(posedge clk_i);
        ext_code_i <= 1'b0;
        $display("test registers done");
        wr(PCA, g | 8'h01, 1'b1);
        @(negedge clk_i);
        chk({cpu_hold_o, cpu_clk_en_o, periph_clk_en_o, ale_o}, 4'b1011);
        @(posedge clk_i);
        rd(PCA, 8'hFF, (g & 8'h0C) | 8'h01);
        irq_enabled_i <= 1'b1;
        @(posedge clk_i);
        irq_enabled_i <= 1'b0;
        wait_hold(1'b0);
        rd(PCA, 8'hFF, g & 8'h0C);
        $display("test idle done");
        for (int i = 0; i < 2; i++) begin
            wr(PCA, 8'h03 - 8'(i), 1'b1);
            @(negedge clk_i);
            chk({osc_enable_o, periph_clk_en_o, ale_o, program_store_strobe_n_o}, 0);
            @(posedge clk_i);
            sel <= i[0];
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            @(negedge clk_i);
            chk(wake_flags_o, 2'b01 << i);
            repeat (10) @(negedge clk_i);
            chk({cpu_hold_o, osc_enable_o}, 2'b11);
            wait_hold(1'b0);
            rd(PCA, 8'h02, 8'h00);
            repeat (3) @(negedge clk_i);
            chk(cpu_hold_o, 1'b0);
            @(posedge clk_i);
        end
        $display("test power-down done");
        for (int i = 0; i < 2; i++) begin
            wr(PCA, 8'h01 << i, 1'b1);
            rst_i <= 1'b1;
            @(negedge clk_i);
            chk({osc_enable_o, cpu_clk_en_o, port0_oe_o, port1_o}, 11'h6FF);
            chk({port2_o, wake_flags_o}, 10'h3FC);
            @(posedge clk_i);
            rst_i <= 1'b0;
            @(negedge clk_i);
            chk(ram_block_o, 1'b1);
            repeat (pmc_pkg::RST_BLOCK_CYC + 2) @(negedge clk_i);
            chk(ram_block_o, 1'b0);
            @(posedge clk_i);
            rd(PCA, 8'hFF, 8'h00);
        end
        $display("test reset done");
        repeat (2) @(posedge clk_i);
        stop_test;
    end
endmodule // pmc_power_ctrl_tb_top
